// File: spt_pkg.sv
// Constants, field layouts and carrier types of the segment/page translator.
// Assumes one core clock; bit 0 of every documented field is the MSB here.
package spt_pkg;

  // Segment register file and lookaside buffer sizes
  localparam int SR_COUNT = 16;
  localparam int SR_IDX_W = 4;
  localparam int TLB_ENTRIES = 4;
  localparam int TLB_IDX_W = 2;

  // Segment descriptor type codes
  localparam logic SEG_MEMORY = 1'b0;
  localparam logic SEG_DIRECT = 1'b1;

  // Values after reset
  localparam logic [31:0] SR_RESET = 32'h0000_0000;
  localparam logic [TLB_IDX_W-1:0] REPL_RESET = 2'h0;

  // Effective address: segment index, page index, byte offset
  typedef struct packed {
    logic [3:0] sr_index;
    logic [15:0] page_index;
    logic [11:0] byte_offset;
  } spt_eaddr_t;

  // Memory-segment descriptor, 32 bits
  typedef struct packed {
    logic segment_type_bit;
    logic supervisor_key;
    logic user_key;
    logic no_execute_bit;
    logic [3:0] reserved;
    logic [23:0] virtual_segment_id;
  } spt_seg_desc_t;

  // Page table entry word 0
  typedef struct packed {
    logic entry_valid;
    logic [23:0] virtual_segment_id;
    logic hash_select;
    logic [5:0] abbreviated_page_index;
  } spt_pte_w0_t;

  // Page table entry word 1
  typedef struct packed {
    logic [19:0] physical_page_number;
    logic [2:0] reserved_a;
    logic referenced_bit;
    logic changed_bit;
    logic [3:0] cache_mode_bits;
    logic reserved_b;
    logic [1:0] page_protection_bits;
  } spt_pte_w1_t;

  // Full 64-bit entry, word 0 in the upper half
  typedef struct packed {
    spt_pte_w0_t w0;
    spt_pte_w1_t w1;
  } spt_pte_t;

  // Virtual page number: segment id then page index
  typedef logic [39:0] spt_vpn_t;

  // Access request from the fetch or data path
  typedef struct packed {
    spt_eaddr_t ea;
    logic is_fetch;
    logic is_write;
    logic supervisor;
  } spt_req_t;

  // How an access was resolved
  typedef enum logic [2:0] {
    KIND_REAL = 3'h0,
    KIND_BLOCK = 3'h1,
    KIND_PAGE = 3'h2,
    KIND_DIRECT = 3'h3,
    KIND_FAULT = 3'h4
  } spt_kind_t;

  // Translation result
  typedef struct packed {
    logic [31:0] phys_addr;
    spt_kind_t kind;
    logic [3:0] cache_mode_bits;
    logic [1:0] page_protection_bits;
    logic supervisor_key;
    logic user_key;
    logic no_execute_bit;
  } spt_rsp_t;

  // Translator states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WALK = 3'b010,
    S_HIST = 3'b100
  } spt_state_t;

endpackage : spt_pkg

// File: spt_translate.sv
// Segment and page address translation front end with a small lookaside
// buffer. Assumes the core presents one access at a time and that an outer
// walker hashes and fetches entry groups and performs history writes.
// Function
// - Descriptor type bit 0 means memory segment, 1 means direct-store.
// - Translation disabled for the access kind selects real addressing.
// - Enabled, no block hit, type clear: do page translation.
// - Enabled, type set: route to direct-store space, no paging.
// - Address bits 0-3 pick a segment register supplying the segment id.
// - Segment id joined with address bits 4-19 forms the virtual page.
// - Virtual page looks up an entry in buffer or table for page number.
// - Physical address is page number followed by address bits 20-31.
// - Sixteen 32-bit on-chip segment registers hold descriptors.
// - Descriptor fields: keys, no-execute, reserved, segment id bits 8-31.
// - Any copies of segment registers stay consistent on every write.
// - Segment register access takes effect only in supervisor mode.
// - A page table entry is 64 bits made of two words.
// - Word 0 holds valid, segment id, hash select, abbreviated index.
// - Word 1 holds page number, history bits, cache mode, protection.
// - Entry matches only if id, hash, valid and abbreviated index agree.
// - Only the abbreviated index is compared; low ten bits go to hash.
// - Lookaside buffer is searched first; a hit skips the table search.
// - History recorded only for page-translated accesses.
// - History updated only while the relevant translation enable is 1.
// - History 00: update R, or R and C on write; 10: C on write.
// - History 11 needs no update for either reads or writes.
module spt_translate (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Access request
  input wire logic i_req_valid,
  input wire spt_pkg::spt_req_t i_req,
  output logic o_req_ready,
  input wire logic i_instruction_translation_enable,
  input wire logic i_data_translation_enable,
  input wire logic i_block_translation_hit,
  input wire logic [31:0] i_block_translation_addr,
  output logic o_rsp_valid,
  output spt_pkg::spt_rsp_t o_rsp,
  // Segment register access
  input wire logic i_sr_wr,
  input wire logic i_sr_rd,
  input wire logic [spt_pkg::SR_IDX_W-1:0] i_sr_idx,
  input wire logic [31:0] i_sr_wdata,
  input wire logic i_sr_supervisor,
  output logic [31:0] o_sr_rdata,
  output logic o_sr_denied,
  input wire logic i_tlb_flush,
  // Page table search
  output logic o_walk_req,
  output spt_pkg::spt_vpn_t o_walk_vpn,
  input wire logic i_walk_valid,
  input wire logic i_walk_found,
  input wire logic i_walk_hash,
  input wire spt_pkg::spt_pte_t i_walk_pte,
  // History write-back
  output logic o_hist_req,
  output spt_pkg::spt_vpn_t o_hist_vpn,
  output spt_pkg::spt_pte_w1_t o_hist_word1,
  input wire logic i_hist_ack
);
  import spt_pkg::*;

  // Entry check against the searched segment and page
  function automatic logic pte_match(input spt_pte_w0_t w0,
                                     input spt_seg_desc_t sd,
                                     input spt_eaddr_t ea,
                                     input logic hash);
    pte_match = w0.entry_valid
      && (w0.virtual_segment_id == sd.virtual_segment_id)
      && (w0.hash_select == hash)
      && (w0.abbreviated_page_index == ea.page_index[15:10]);
  endfunction : pte_match

  // Whether the history bits call for a table update
  function automatic logic hist_needed(input spt_pte_w1_t w1,
                                       input logic wr);
    hist_needed = !w1.referenced_bit || (wr && !w1.changed_bit);
  endfunction : hist_needed

  // History bits after the access
  function automatic spt_pte_w1_t hist_set(input spt_pte_w1_t w1,
                                           input logic wr);
    hist_set = w1;
    hist_set.referenced_bit = 1'b1;
    hist_set.changed_bit = w1.changed_bit | wr;
  endfunction : hist_set

  // Result of a page-translated access
  function automatic spt_rsp_t page_rsp(input spt_pte_w1_t w1,
                                        input spt_seg_desc_t sd,
                                        input spt_eaddr_t ea);
    page_rsp.phys_addr = {w1.physical_page_number, ea.byte_offset};
    page_rsp.kind = KIND_PAGE;
    page_rsp.cache_mode_bits = w1.cache_mode_bits;
    page_rsp.page_protection_bits = w1.page_protection_bits;
    page_rsp.supervisor_key = sd.supervisor_key;
    page_rsp.user_key = sd.user_key;
    page_rsp.no_execute_bit = sd.no_execute_bit;
  endfunction : page_rsp

  // Result of an access that bypasses paging
  function automatic spt_rsp_t flat_rsp(input spt_kind_t kind,
                                        input logic [31:0] pa,
                                        input spt_seg_desc_t sd);
    flat_rsp.phys_addr = pa;
    flat_rsp.kind = kind;
    flat_rsp.cache_mode_bits = 4'h0;
    flat_rsp.page_protection_bits = 2'h0;
    flat_rsp.supervisor_key = sd.supervisor_key;
    flat_rsp.user_key = sd.user_key;
    flat_rsp.no_execute_bit = sd.no_execute_bit;
  endfunction : flat_rsp

  // One shared descriptor file serves fetch and data, so no copy can drift
  logic [31:0] sr_q [SR_COUNT];
  logic [31:0] sr_d [SR_COUNT];
  logic tlb_v_q [TLB_ENTRIES];
  logic tlb_v_d [TLB_ENTRIES];
  spt_vpn_t tlb_vpn_q [TLB_ENTRIES];
  spt_vpn_t tlb_vpn_d [TLB_ENTRIES];
  spt_pte_w1_t tlb_w1_q [TLB_ENTRIES];
  spt_pte_w1_t tlb_w1_d [TLB_ENTRIES];
  logic [TLB_IDX_W-1:0] repl_q, repl_d;
  spt_state_t state_q, state_d;
  spt_req_t req_q, req_d;
  spt_seg_desc_t desc_q, desc_d;
  spt_vpn_t vpn_q, vpn_d;
  spt_pte_w1_t w1_q, w1_d;
  logic rsp_valid_q, rsp_valid_d;
  spt_rsp_t rsp_q, rsp_d;
  logic [31:0] sr_rd_q, sr_rd_d;
  logic sr_denied_q, sr_denied_d;

  // Lookup scratch
  spt_seg_desc_t desc;
  spt_vpn_t virtual_page_number;
  logic tr_en;
  logic hit;
  logic [TLB_IDX_W-1:0] hit_idx;
  spt_pte_w1_t hit_w1;

  // Next-state logic for the whole translator
  always_comb begin
    sr_d = sr_q;
    tlb_v_d = tlb_v_q;
    tlb_vpn_d = tlb_vpn_q;
    tlb_w1_d = tlb_w1_q;
    repl_d = repl_q;
    state_d = state_q;
    req_d = req_q;
    desc_d = desc_q;
    vpn_d = vpn_q;
    w1_d = w1_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    sr_rd_d = sr_rd_q;
    sr_denied_d = 1'b0;
    hit = 1'b0;
    hit_idx = '0;
    hit_w1 = tlb_w1_q[0];

    // User-mode descriptor access is dropped and flagged
    if (i_sr_wr || i_sr_rd) begin
      if (i_sr_supervisor) begin
        if (i_sr_wr) begin
          sr_d[i_sr_idx] = i_sr_wdata;
        end
        if (i_sr_rd) begin
          sr_rd_d = sr_q[i_sr_idx];
        end
      end else begin
        sr_denied_d = 1'b1;
      end
    end

    // Segment selection and virtual page formation
    desc = spt_seg_desc_t'(sr_q[i_req.ea.sr_index]);
    virtual_page_number = {desc.virtual_segment_id, i_req.ea.page_index};
    tr_en = i_req.is_fetch ? i_instruction_translation_enable
                           : i_data_translation_enable;

    // Fully associative search; entries hold distinct pages
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      if (tlb_v_q[i] && (tlb_vpn_q[i] == virtual_page_number)) begin
        hit = 1'b1;
        hit_idx = TLB_IDX_W'(i);
        hit_w1 = tlb_w1_q[i];
      end
    end

    unique case (state_q)
      S_IDLE: begin
        if (i_req_valid) begin
          req_d = i_req;
          desc_d = desc;
          vpn_d = virtual_page_number;
          if (!tr_en) begin
            rsp_valid_d = 1'b1;
            rsp_d = flat_rsp(KIND_REAL, i_req.ea, desc);
          end else if (desc.segment_type_bit == SEG_DIRECT) begin
            rsp_valid_d = 1'b1;
            rsp_d = flat_rsp(KIND_DIRECT, i_req.ea, desc);
          end else if (i_block_translation_hit) begin
            rsp_valid_d = 1'b1;
            rsp_d = flat_rsp(KIND_BLOCK, i_block_translation_addr, desc);
          end else if (hit) begin
            // Buffer copy answers; history bits judged on that copy
            if (hist_needed(hit_w1, i_req.is_write)) begin
              w1_d = hist_set(hit_w1, i_req.is_write);
              tlb_w1_d[hit_idx] = hist_set(hit_w1, i_req.is_write);
              state_d = S_HIST;
            end else begin
              rsp_valid_d = 1'b1;
              rsp_d = page_rsp(hit_w1, desc, i_req.ea);
            end
          end else begin
            state_d = S_WALK;
          end
        end
      end
      S_WALK: begin
        if (i_walk_valid) begin
          if (i_walk_found && pte_match(i_walk_pte.w0, desc_q, req_q.ea,
                                        i_walk_hash)) begin
            tlb_v_d[repl_q] = 1'b1;
            tlb_vpn_d[repl_q] = vpn_q;
            tlb_w1_d[repl_q] = hist_set(i_walk_pte.w1, req_q.is_write);
            repl_d = repl_q + TLB_IDX_W'(1);
            if (hist_needed(i_walk_pte.w1, req_q.is_write)) begin
              w1_d = hist_set(i_walk_pte.w1, req_q.is_write);
              state_d = S_HIST;
            end else begin
              rsp_valid_d = 1'b1;
              rsp_d = page_rsp(i_walk_pte.w1, desc_q, req_q.ea);
              state_d = S_IDLE;
            end
          end else begin
            // No matching entry: report a page fault to the core
            rsp_valid_d = 1'b1;
            rsp_d = flat_rsp(KIND_FAULT, req_q.ea, desc_q);
            state_d = S_IDLE;
          end
        end
      end
      S_HIST: begin
        if (i_hist_ack) begin
          rsp_valid_d = 1'b1;
          rsp_d = page_rsp(w1_q, desc_q, req_q.ea);
          state_d = S_IDLE;
        end
      end
    endcase

    // Flush wins over a same-cycle install; stale copies must not survive
    if (i_tlb_flush) begin
      for (int i = 0; i < TLB_ENTRIES; i++) begin
        tlb_v_d[i] = 1'b0;
      end
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < SR_COUNT; i++) begin
        sr_q[i] <= SR_RESET;
      end
      for (int i = 0; i < TLB_ENTRIES; i++) begin
        tlb_v_q[i] <= 1'b0;
        tlb_vpn_q[i] <= '0;
        tlb_w1_q[i] <= '0;
      end
      repl_q <= REPL_RESET;
      state_q <= S_IDLE;
      req_q <= '0;
      desc_q <= '0;
      vpn_q <= '0;
      w1_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      sr_rd_q <= SR_RESET;
      sr_denied_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      tlb_v_q <= tlb_v_d;
      tlb_vpn_q <= tlb_vpn_d;
      tlb_w1_q <= tlb_w1_d;
      repl_q <= repl_d;
      state_q <= state_d;
      req_q <= req_d;
      desc_q <= desc_d;
      vpn_q <= vpn_d;
      w1_q <= w1_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      sr_rd_q <= sr_rd_d;
      sr_denied_q <= sr_denied_d;
    end
  end

  // Handshakes from state, data from flops
  assign o_req_ready = (state_q == S_IDLE) && !rsp_valid_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp = rsp_q;
  assign o_sr_rdata = sr_rd_q;
  assign o_sr_denied = sr_denied_q;
  assign o_walk_req = (state_q == S_WALK);
  assign o_walk_vpn = vpn_q;
  assign o_hist_req = (state_q == S_HIST);
  assign o_hist_vpn = vpn_q;
  assign o_hist_word1 = w1_q;

endmodule : spt_translate

// File: spt_walker_model.sv
// Page table walker and history writer model facing the translator.
// Assumes the bench sets the entry to return and the answer delay.
module spt_walker_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_walk_req,
  input wire logic i_hist_req,
  input wire spt_pkg::spt_pte_t i_pte,
  input wire logic [3:0] i_delay,
  output logic o_walk_valid,
  output logic o_walk_found,
  output logic o_walk_hash,
  output spt_pkg::spt_pte_t o_walk_pte,
  output logic o_hist_ack
);
  import spt_pkg::*;
  logic [3:0] cnt_q;
  logic hit_q;
  logic busy;
  // Strobes only while a request stands; idle lines show inverted data
  assign busy = (i_walk_req || i_hist_req) && !hit_q;
  assign o_walk_valid = hit_q && i_walk_req;
  assign o_hist_ack = hit_q && i_hist_req;
  assign o_walk_found = hit_q;
  assign o_walk_hash = !hit_q;
  assign o_walk_pte = hit_q ? i_pte : ~i_pte;
  // Wait i_delay+1 cycles, then one strobe per request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      hit_q <= 1'b0;
    end else begin
      hit_q <= busy && cnt_q == i_delay;
      cnt_q <= (busy && cnt_q != i_delay) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : spt_walker_model

// File: spt_translate_asserts.sv
// Port checker for the segment/page translator.
// Assumes one core clock and the active-low asynchronous reset.
module spt_translate_asserts
  import spt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire spt_pkg::spt_req_t i_req,
  input wire logic o_req_ready,
  input wire logic i_instruction_translation_enable,
  input wire logic i_data_translation_enable,
  input wire logic o_rsp_valid,
  input wire spt_pkg::spt_rsp_t o_rsp,
  input wire logic o_walk_req,
  input wire spt_pkg::spt_vpn_t o_walk_vpn,
  input wire logic i_walk_valid,
  input wire logic i_walk_found,
  input wire logic i_walk_hash,
  input wire spt_pkg::spt_pte_t i_walk_pte,
  input wire logic o_hist_req
);
  logic take, real_acc, hit_ok;
  logic [31:0] ea_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Request decode and entry match against the page being searched
  assign take = i_req_valid && o_req_ready;
  assign real_acc = i_req.is_fetch ? !i_instruction_translation_enable
                                   : !i_data_translation_enable;
  assign hit_ok = i_walk_found && i_walk_pte.w0.entry_valid &&
    i_walk_pte.w0.virtual_segment_id == o_walk_vpn[39:16] &&
    i_walk_pte.w0.hash_select == i_walk_hash &&
    i_walk_pte.w0.abbreviated_page_index == o_walk_vpn[15:10];
  // Address of the access in flight
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ea_q <= 32'h0000_0000;
    end else if (take) begin
      ea_q <= i_req.ea;
    end
  end
  a_take_drops:
    assert property (take |=> !o_req_ready)
    else $error("ready held after a take");
  a_real_addr:
    assert property (take && real_acc |=> o_rsp_valid &&
      o_rsp.kind == KIND_REAL && o_rsp.phys_addr == ea_q)
    else $error("real answer wrong");
  a_pass_addr:
    assert property (o_rsp_valid && o_rsp.kind == KIND_DIRECT
      |-> o_rsp.phys_addr == ea_q)
    else $error("direct address changed");
  a_page_offset:
    assert property (o_rsp_valid && o_rsp.kind == KIND_PAGE
      |-> o_rsp.phys_addr[11:0] == ea_q[11:0])
    else $error("byte offset altered");
  a_walk_vpn:
    assert property ($rose(o_walk_req) |-> o_walk_vpn[15:0] == ea_q[27:12])
    else $error("page index missing in search");
  a_walk_fault:
    assert property (o_walk_req && i_walk_valid && !hit_ok
      |=> o_rsp_valid && o_rsp.kind == KIND_FAULT)
    else $error("mismatch not faulted");
  a_page_ppn:
    assert property (o_walk_req && i_walk_valid && hit_ok &&
      i_walk_pte.w1.referenced_bit && i_walk_pte.w1.changed_bit
      |=> o_rsp_valid && !o_hist_req && o_rsp.kind == KIND_PAGE &&
      o_rsp.phys_addr[31:12] == $past(i_walk_pte.w1.physical_page_number))
    else $error("page number wrong");
  a_hist_needed:
    assert property (o_walk_req && i_walk_valid && hit_ok &&
      !i_walk_pte.w1.referenced_bit |=> o_hist_req && !o_rsp_valid)
    else $error("history write missing");
endmodule : spt_translate_asserts

bind spt_translate spt_translate_asserts u_spt_chk (.i_clk, .i_rst_n,
  .i_req_valid, .i_req, .o_req_ready, .i_instruction_translation_enable,
  .i_data_translation_enable, .o_rsp_valid, .o_rsp, .o_walk_req,
  .o_walk_vpn, .i_walk_valid, .i_walk_found, .i_walk_hash, .i_walk_pte,
  .o_hist_req);

// File: spt_translate_bench.sv
// Self-checking bench for the segment/page translator.
// Assumes the walker model answers every search and history write.
module spt_translate_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import spt_pkg::*;
  localparam logic [31:0] EA = 32'h5ABC_D123;
  localparam logic [31:0] PA = 32'h7123_4123;
  logic i_clk, i_rst_n, i_req_valid, o_req_ready, i_tlb_flush, o_rsp_valid;
  logic i_sr_wr, i_sr_rd, i_sr_supervisor, o_sr_denied, o_walk_req;
  logic i_walk_valid, i_walk_found, i_walk_hash, o_hist_req, i_hist_ack;
  logic i_instruction_translation_enable, i_data_translation_enable;
  logic i_block_translation_hit, wseen, hseen;
  logic [3:0] i_sr_idx, dly;
  logic [31:0] i_block_translation_addr, i_sr_wdata, o_sr_rdata;
  spt_req_t i_req;
  spt_rsp_t o_rsp;
  spt_pte_t page_table_entry, i_walk_pte;
  spt_pte_w1_t o_hist_word1, w1;
  spt_vpn_t o_hist_vpn, hv;
  int error_cnt, cmp_count;

  spt_translate DUT (.i_clk, .i_rst_n, .i_req_valid, .i_req, .o_req_ready,
    .i_instruction_translation_enable, .i_data_translation_enable,
    .i_block_translation_hit, .i_block_translation_addr, .o_rsp_valid,
    .o_rsp, .i_sr_wr, .i_sr_rd, .i_sr_idx, .i_sr_wdata, .i_sr_supervisor,
    .o_sr_rdata, .o_sr_denied, .i_tlb_flush, .o_walk_req, .o_walk_vpn(),
    .i_walk_valid, .i_walk_found, .i_walk_hash, .i_walk_pte, .o_hist_req,
    .o_hist_vpn, .o_hist_word1, .i_hist_ack);
  spt_walker_model u_walker (.i_clk, .i_rst_n, .i_walk_req(o_walk_req),
    .i_hist_req(o_hist_req), .i_pte(page_table_entry), .i_delay(dly),
    .o_walk_valid(i_walk_valid), .o_walk_found(i_walk_found),
    .o_walk_hash(i_walk_hash), .o_walk_pte(i_walk_pte),
    .o_hist_ack(i_hist_ack));

  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Entry for segment id 12_3456; hash and index vary per scenario
  function automatic spt_pte_t mk(input logic r, c, h, input logic [5:0] a);
    mk = '0;
    mk.w0 = {1'b1, 24'h12_3456, h, a};
    mk.w1.physical_page_number = 20'h7_1234;
    mk.w1.referenced_bit = r;
    mk.w1.changed_bit = c;
    mk.w1.cache_mode_bits = 4'h5;
    mk.w1.page_protection_bits = 2'h2;
  endfunction : mk

  // One access; idle translator takes it at the first edge
  task automatic acc(input logic [31:0] ea, input logic f, w, ie, de, bh);
    int n;
    n = 0;
    wseen = 1'b0;
    hseen = 1'b0;
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req <= {ea, f, w, 1'b1};
    i_instruction_translation_enable <= ie;
    i_data_translation_enable <= de;
    i_block_translation_hit <= bh;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
      if (o_walk_req === 1'b1) wseen = 1'b1;
      if (o_hist_req === 1'b1) begin
        hseen = 1'b1;
        w1 = o_hist_word1;
        hv = o_hist_vpn;
      end
    end while (o_rsp_valid !== 1'b1 && n < 100);
    if (o_rsp_valid !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask : acc

  task automatic srw(input logic w, s, input logic [3:0] i,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_sr_wr <= w;
    i_sr_rd <= !w;
    i_sr_supervisor <= s;
    i_sr_idx <= i;
    i_sr_wdata <= d;
    @(posedge i_clk);
    i_sr_wr <= 1'b0;
    i_sr_rd <= 1'b0;
    @(negedge i_clk);
  endtask : srw

  // Flush the buffer and load the walker's next entry and delay
  task automatic fl(input logic [3:0] d, input spt_pte_t p);
    @(posedge i_clk);
    i_tlb_flush <= 1'b1;
    dly <= d;
    page_table_entry <= p;
    @(posedge i_clk);
    i_tlb_flush <= 1'b0;
  endtask : fl

  task automatic t_sr();
    srw(1'b0, 1'b1, 4'h0, '0);
    chk("sr0", o_sr_rdata, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      srw(1'b1, 1'b1, i[3:0], {8'h00, i[7:0], 16'h5A5A});
    end
    for (int i = 0; i < 16; i++) begin
      srw(1'b0, 1'b1, i[3:0], '0);
      chk("sr", o_sr_rdata, {8'h00, i[7:0], 16'h5A5A});
    end
    srw(1'b1, 1'b0, 4'h3, 32'hFFFF_FFFF);
    chk("denied", o_sr_denied, 1'b1);
    srw(1'b0, 1'b1, 4'h3, '0);
    chk("sr3", o_sr_rdata, 32'h0003_5A5A);
    // Both keys set so the page answer shows them
    srw(1'b1, 1'b1, 4'h5, 32'h6012_3456);
    srw(1'b1, 1'b1, 4'h9, 32'h8000_0000);
  endtask : t_sr

  task automatic t_route();
    acc(EA, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("fetch", o_rsp.kind, KIND_REAL);
    chk("no walk", {wseen, hseen}, 2'b00);
    acc(EA, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk("data", o_rsp.kind, KIND_REAL);
    acc(32'h9000_0010, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    chk("direct", o_rsp.kind, KIND_DIRECT);
    chk("direct walk", wseen, 1'b0);
    acc(EA, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    chk("block", o_rsp.kind, KIND_BLOCK);
    chk("block pa", o_rsp.phys_addr, 32'h0ABC_0123);
    chk("block hist", {wseen, hseen}, 2'b00);
  endtask : t_route

  task automatic t_page();
    fl(4'h3, mk(1'b1, 1'b1, 1'b0, 6'h2A));
    acc(EA, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("page", o_rsp.kind, KIND_PAGE);
    chk("page pa", o_rsp.phys_addr, PA);
    chk("walk", wseen, 1'b1);
    chk("keys", {o_rsp.supervisor_key, o_rsp.user_key}, 2'b11);
    chk("no exec", o_rsp.no_execute_bit, 1'b0);
    chk("mode prot", {o_rsp.cache_mode_bits, o_rsp.page_protection_bits},
        6'h16);
    // Fetch side reads the same descriptor set as the data side
    acc(EA, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("fetch page", o_rsp.phys_addr, PA);
    acc(EA, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("hit pa", o_rsp.phys_addr, PA);
    chk("hit", {wseen, hseen}, 2'b00);
  endtask : t_page

  task automatic t_hist();
    fl(4'h0, mk(1'b0, 1'b0, 1'b0, 6'h2A));
    acc(EA, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("rc", {hseen, w1.referenced_bit, w1.changed_bit}, 3'b111);
    chk("rc pa", o_rsp.phys_addr, PA);
    chk("hist sid", hv[39:32], 8'h12);
    chk("hist vpn", hv[31:0], 32'h3456_ABCD);
    fl(4'h1, mk(1'b1, 1'b0, 1'b0, 6'h2A));
    acc(EA, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("read", hseen, 1'b0);
    acc(EA, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("c", {hseen, w1.changed_bit}, 2'b11);
  endtask : t_hist

  task automatic t_fault();
    fl(4'h0, mk(1'b1, 1'b1, 1'b0, 6'h15));
    acc(EA, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("api", o_rsp.kind, KIND_FAULT);
    fl(4'h2, mk(1'b1, 1'b1, 1'b1, 6'h2A));
    acc(EA, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("hash", o_rsp.kind, KIND_FAULT);
  endtask : t_fault

  // 10 MHz core clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Six cycles of reset, then the scenarios in turn
  initial begin
    {i_rst_n, i_req_valid, i_sr_wr, i_sr_rd, i_sr_supervisor} = '0;
    {i_instruction_translation_enable, i_data_translation_enable} = '0;
    {i_block_translation_hit, i_tlb_flush, i_sr_idx, dly} = '0;
    {i_req, i_sr_wdata, page_table_entry} = '0;
    i_block_translation_addr = 32'h0ABC_0123;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_sr();
    t_route();
    t_page();
    t_hist();
    t_fault();
    summarize();
  end
endmodule : spt_translate_bench
